/* spf_pkg.sv */
// Shared constants and types of the sleep power and output format block
package spf_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;
    localparam int SAMP_W   = 12;
    localparam int N_SAMP   = 7;
    localparam int IDLE_W   = 12;
    localparam int CODE_W   = 4;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] TEMP_OUT  = 8'h01;
    localparam logic [7:0] OUT_X_L   = 8'h04;
    localparam logic [7:0] OUT_Y_L   = 8'h06;
    localparam logic [7:0] VECTOR_MAGNITUDE_OUTPUT_L    = 8'h0A;
    localparam logic [7:0] VECTOR_MAGNITUDE_OUTPUT_H    = 8'h0B;
    localparam logic [7:0] BUF_X_L   = 8'h0C;
    localparam logic [7:0] BUF_Z_L   = 8'h10;
    localparam logic [7:0] BUF_Z_H   = 8'h11;
    localparam logic [7:0] SETUP_TWO = 8'h16;
    localparam logic [7:0] RATE_DEC  = 8'h17;
    localparam logic [7:0] IDLE_L    = 8'h1A;
    localparam logic [7:0] IDLE_H    = 8'h1B;
    localparam logic [7:0] STATUS    = 8'h1C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SLP_PM_HI  = 5;
    localparam int SLP_PM_LO  = 4;
    localparam int BYTE_ORDER = 3;
    localparam int TEMP_AINC  = 1;
    localparam int FAST_READ  = 0;
    localparam int WARN_BIT   = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  SETUP_TWO_RST = 8'h00;
    localparam logic [7:0]  RATE_DEC_RST  = 8'h00;
    localparam logic [11:0] IDLE_RST      = 12'h000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        SPF_LPM,
        SPF_HPM,
        SPF_FPM
    } spf_sleep_mode_t;

    typedef struct packed {
        logic [SAMP_W-1:0] x;
        logic [SAMP_W-1:0] y;
        logic [SAMP_W-1:0] z;
    } spf_axis_t;

    typedef struct packed {
        spf_sleep_mode_t   mode;
        logic [CODE_W-1:0] rate_code;
        logic [CODE_W-1:0] dec_code;
        logic [IDLE_W-1:0] idle;
    } spf_sleep_cfg_t;

endpackage

/* spf_sample_fmt.sv */
// Byte layout of one 12-bit output sample
`timescale 1ns/1ps
module spf_sample_fmt (
    input  wire logic [11:0] sample,
    input  wire logic        byte_order_select,
    input  wire logic        fast_read,
    output logic      [7:0]  lo_byte,
    output logic      [7:0]  hi_byte
);

    always_comb begin
        if (fast_read) begin
            // Msb byte low whatever the order
            lo_byte = sample[11:4];
            hi_byte = 8'h00;
        end else if (byte_order_select) begin
            // Msbs low, lsb nibble left-justified
            lo_byte = sample[11:4];
            hi_byte = {sample[3:0], 4'h0};
        end else begin
            // Lsbs low, msb nibble right-justified
            lo_byte = sample[7:0];
            hi_byte = {4'h0, sample[11:8]};
        end
    end

endmodule

/* spf_ptr_step.sv */
// Next address of the auto-increment pointer after a read
`timescale 1ns/1ps
module spf_ptr_step (
    input  wire logic [7:0] addr,
    input  wire logic       fast_read,
    input  wire logic       temp_autoinc_include,
    output logic      [7:0] next_addr
);

    logic [7:0] stride;
    logic [7:0] wrap_cur;

    always_comb begin
        // Even address is a low byte; fast mode jumps the high one
        stride = (fast_read && !addr[0]) ? 8'h02 : 8'h01;
        // Temp joins the loop only when asked
        wrap_cur = temp_autoinc_include ? spf_pkg::TEMP_OUT
                                        : spf_pkg::OUT_X_L;
        if (addr == spf_pkg::TEMP_OUT) begin
            next_addr = spf_pkg::OUT_X_L;
        end else if (addr >= spf_pkg::OUT_X_L
                     && addr <= spf_pkg::VECTOR_MAGNITUDE_OUTPUT_H) begin
            if (addr == spf_pkg::VECTOR_MAGNITUDE_OUTPUT_H
                || (fast_read && addr == spf_pkg::VECTOR_MAGNITUDE_OUTPUT_L)) begin
                next_addr = wrap_cur;
            end else begin
                next_addr = addr + stride;
            end
        end else if (addr >= spf_pkg::BUF_X_L
                     && addr <= spf_pkg::BUF_Z_H) begin
            if (addr == spf_pkg::BUF_Z_H
                || (fast_read && addr == spf_pkg::BUF_Z_L)) begin
                next_addr = spf_pkg::BUF_X_L;
            end else begin
                next_addr = addr + stride;
            end
        end else begin
            next_addr = addr + 8'h01;
        end
    end

endmodule

/* spf_setup_two.sv */
// Sleep power selector, output format and read pointer logic
`timescale 1ns/1ps
module spf_setup_two (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire spf_pkg::spf_axis_t    cur_axis,
    input  wire spf_pkg::spf_axis_t    buf_axis,
    input  wire logic [11:0]           vector_magnitude_output_data,
    input  wire logic [7:0]            temp_data,
    input  wire logic                  boot_mode_pin,
    output spf_pkg::spf_sleep_cfg_t    sleep_cfg,
    output logic      [7:0]            auto_inc_addr,
    output logic                       config_warn
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0]               setup_two_reg;
    logic [7:0]               rate_dec_reg;
    logic [11:0]              idle_reg;
    logic [7:0]               rdata_reg;
    logic [7:0]               rdata_next;
    logic [7:0]               ptr_reg;
    logic [7:0]               ptr_next;
    logic                     boot_s1_reg;
    logic                     boot_s2_reg;
    logic                     warn_reg;
    spf_pkg::spf_sleep_cfg_t  cfg_reg;
    spf_pkg::spf_sleep_cfg_t  cfg_next;

    logic [1:0]               sleep_power_select;
    logic                     byte_order_select;
    logic                     temp_autoinc_include;
    logic                     fast_read;
    logic [3:0]               sleep_nibble;

    logic [11:0]              samp  [spf_pkg::N_SAMP];
    logic [7:0]               lo_b  [spf_pkg::N_SAMP];
    logic [7:0]               hi_b  [spf_pkg::N_SAMP];
    logic [7:0]               off;

    assign sleep_power_select   = setup_two_reg[spf_pkg::SLP_PM_HI:
                                                spf_pkg::SLP_PM_LO];
    assign byte_order_select    = setup_two_reg[spf_pkg::BYTE_ORDER];
    assign temp_autoinc_include = setup_two_reg[spf_pkg::TEMP_AINC];
    assign fast_read            = setup_two_reg[spf_pkg::FAST_READ];
    assign sleep_nibble         = rate_dec_reg[3:0];

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            setup_two_reg <= spf_pkg::SETUP_TWO_RST;
        end else if (reg_wr && reg_addr == spf_pkg::SETUP_TWO) begin
            setup_two_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rate_dec_reg <= spf_pkg::RATE_DEC_RST;
        end else if (reg_wr && reg_addr == spf_pkg::RATE_DEC) begin
            rate_dec_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idle_reg <= spf_pkg::IDLE_RST;
        end else if (reg_wr && reg_addr == spf_pkg::IDLE_L) begin
            idle_reg[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == spf_pkg::IDLE_H) begin
            idle_reg[11:8] <= reg_wdata[3:0];
        end
    end

    // ****************************************************************
    // Sleep mode decode
    // ****************************************************************
    always_comb begin
        cfg_next = '0;
        if (sleep_power_select[1]) begin
            cfg_next.mode     = spf_pkg::SPF_FPM;
            cfg_next.dec_code = sleep_nibble;
            cfg_next.idle     = idle_reg;
        end else if (sleep_power_select[0]) begin
            cfg_next.mode      = spf_pkg::SPF_HPM;
            cfg_next.rate_code = sleep_nibble;
        end else begin
            cfg_next.mode      = spf_pkg::SPF_LPM;
            cfg_next.rate_code = sleep_nibble;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ****************************************************************
    // Boot pin watch
    // ****************************************************************
    // Flag only; the selector stays software's to fix
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            boot_s1_reg <= 1'b0;
            boot_s2_reg <= 1'b0;
            warn_reg    <= 1'b0;
        end else begin
            boot_s1_reg <= boot_mode_pin;
            boot_s2_reg <= boot_s1_reg;
            warn_reg    <= boot_s2_reg
                           && sleep_power_select != 2'b00;
        end
    end

    // ****************************************************************
    // Sample formatting
    // ****************************************************************
    assign samp[0] = cur_axis.x;
    assign samp[1] = cur_axis.y;
    assign samp[2] = cur_axis.z;
    assign samp[3] = vector_magnitude_output_data;
    assign samp[4] = buf_axis.x;
    assign samp[5] = buf_axis.y;
    assign samp[6] = buf_axis.z;

    // Only these seven samples see the order bit
    for (genvar i = 0; i < spf_pkg::N_SAMP; i++) begin : g_fmt
        spf_sample_fmt u_fmt (
            .sample            (samp[i]),
            .byte_order_select (byte_order_select),
            .fast_read         (fast_read),
            .lo_byte           (lo_b[i]),
            .hi_byte           (hi_b[i])
        );
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    assign off = reg_addr - spf_pkg::OUT_X_L;

    always_comb begin
        if (reg_addr == spf_pkg::TEMP_OUT) begin
            rdata_next = temp_data;
        end else if (reg_addr >= spf_pkg::OUT_X_L
                     && reg_addr <= spf_pkg::BUF_Z_H) begin
            rdata_next = off[0] ? hi_b[off[3:1]] : lo_b[off[3:1]];
        end else if (reg_addr == spf_pkg::SETUP_TWO) begin
            rdata_next = setup_two_reg;
        end else if (reg_addr == spf_pkg::RATE_DEC) begin
            rdata_next = rate_dec_reg;
        end else if (reg_addr == spf_pkg::IDLE_L) begin
            rdata_next = idle_reg[7:0];
        end else if (reg_addr == spf_pkg::IDLE_H) begin
            rdata_next = {4'h0, idle_reg[11:8]};
        end else if (reg_addr == spf_pkg::STATUS) begin
            rdata_next = {7'h00, warn_reg};
        end else begin
            rdata_next = 8'h00;
        end
    end

    // Data stand one cycle only, so stale reads never alias
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // ****************************************************************
    // Auto-increment pointer
    // ****************************************************************
    spf_ptr_step u_step (
        .addr                 (reg_addr),
        .fast_read            (fast_read),
        .temp_autoinc_include (temp_autoinc_include),
        .next_addr            (ptr_next)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ptr_reg <= 8'h00;
        end else if (reg_rd) begin
            ptr_reg <= ptr_next;
        end
    end

    assign reg_rdata     = rdata_reg;
    assign sleep_cfg     = cfg_reg;
    assign auto_inc_addr = ptr_reg;
    assign config_warn   = warn_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_lpm_decode: assert property (
        sleep_power_select == 2'b00
        |=> sleep_cfg.mode == spf_pkg::SPF_LPM
            && sleep_cfg.rate_code == $past(sleep_nibble))
        else $error("low-power sleep decode wrong");

    a_hpm_decode: assert property (
        sleep_power_select == 2'b01
        |=> sleep_cfg.mode == spf_pkg::SPF_HPM
            && sleep_cfg.rate_code == $past(sleep_nibble))
        else $error("high performance sleep decode wrong");

    a_fpm_decode: assert property (
        sleep_power_select[1]
        |=> sleep_cfg.mode == spf_pkg::SPF_FPM
            && sleep_cfg.dec_code == $past(sleep_nibble)
            && sleep_cfg.idle == $past(idle_reg))
        else $error("flexible sleep decode wrong");

    a_boot_warn: assert property (
        boot_s2_reg && sleep_power_select != 2'b00
        |=> config_warn)
        else $error("boot mode warning missing");

    a_le_layout: assert property (
        reg_rd && reg_addr == spf_pkg::VECTOR_MAGNITUDE_OUTPUT_H
        && !byte_order_select && !fast_read
        |=> reg_rdata == {4'h0, $past(vector_magnitude_output_data[11:8])})
        else $error("little-endian high byte wrong");

    a_be_layout: assert property (
        reg_rd && reg_addr == spf_pkg::OUT_X_L
        && byte_order_select && !fast_read
        |=> reg_rdata == $past(cur_axis.x[11:4]))
        else $error("big-endian low byte wrong");

    a_fixed_le: assert property (
        reg_rd && reg_addr == spf_pkg::IDLE_L
        |=> reg_rdata == $past(idle_reg[7:0]))
        else $error("fixed field not little-endian");

    a_temp_range: assert property (
        reg_rd && reg_addr == spf_pkg::VECTOR_MAGNITUDE_OUTPUT_H
        |=> auto_inc_addr == ($past(temp_autoinc_include)
            ? spf_pkg::TEMP_OUT : spf_pkg::OUT_X_L))
        else $error("temperature range handling wrong");

    a_fast_msb: assert property (
        reg_rd && reg_addr == spf_pkg::OUT_Y_L && fast_read
        |=> reg_rdata == $past(cur_axis.y[11:4]))
        else $error("fast read byte wrong");

    a_fast_skip: assert property (
        reg_rd && reg_addr == spf_pkg::OUT_X_L && fast_read
        |=> auto_inc_addr == spf_pkg::OUT_Y_L)
        else $error("fast read pointer did not skip");

    c_fpm_sleep: cover property (
        reg_wr && reg_addr == spf_pkg::SETUP_TWO && reg_wdata[5]
        ##2 sleep_cfg.mode == spf_pkg::SPF_FPM);

    c_fast_burst: cover property (
        reg_rd && fast_read ##1 reg_rd ##1 reg_rd);

    c_temp_wrap: cover property (
        reg_rd && reg_addr == spf_pkg::VECTOR_MAGNITUDE_OUTPUT_H && temp_autoinc_include);

endmodule

/* spf_host_model.sv */
// Host model that drives the register port of the block
`timescale 1ns/1ps
module spf_host_model (
    input  wire logic       ref_clk,
    input  wire logic       boot_mode_pin,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    bit allow_breach;

    initial begin
        allow_breach = 1'b0;
        reg_addr     = 8'hFF;
        reg_wdata    = 8'hFF;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
    end

    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // Sleep stays low power under motion boot unless a test says so
        if (boot_mode_pin && !allow_breach
            && a == spf_pkg::SETUP_TWO) begin
            v[5:4] = 2'b00;
        end
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        // Released lines show the inverse, never a stale value
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

/* tb.sv */
// Self-checking bench of the sleep power and output format block
`timescale 1ns/1ps
module tb;
    logic                    ref_clk;
    logic                    resetn;
    logic [7:0]              reg_addr;
    logic [7:0]              reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [7:0]              reg_rdata;
    spf_pkg::spf_axis_t      cur_axis;
    spf_pkg::spf_axis_t      buf_axis;
    logic [11:0]             vector_magnitude_output_data;
    logic [7:0]              temp_data;
    logic                    boot_mode_pin;
    spf_pkg::spf_sleep_cfg_t sleep_cfg;
    logic [7:0]              auto_inc_addr;
    logic                    config_warn;
    int                      fails;
    int                      cmp_count;
    logic [7:0]              m_setup;
    logic [7:0]              m_rate;
    logic [11:0]             m_idle;
    logic [7:0]              got;

    spf_host_model u_host (
        .ref_clk       (ref_clk),
        .boot_mode_pin (boot_mode_pin),
        .reg_rdata     (reg_rdata),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd)
    );

    spf_setup_two u_dut (
        .ref_clk       (ref_clk),
        .resetn        (resetn),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .cur_axis      (cur_axis),
        .buf_axis      (buf_axis),
        .vector_magnitude_output_data     (vector_magnitude_output_data),
        .temp_data     (temp_data),
        .boot_mode_pin (boot_mode_pin),
        .sleep_cfg     (sleep_cfg),
        .auto_inc_addr (auto_inc_addr),
        .config_warn   (config_warn)
    );

    // ****************************************************************
    // Reference model
    // ****************************************************************
    function automatic logic [7:0] fmt(logic [11:0] s, logic hi);
        if (m_setup[0]) return hi ? 8'h00 : s[11:4];
        if (m_setup[3]) return hi ? {s[3:0], 4'h0} : s[11:4];
        return hi ? {4'h0, s[11:8]} : s[7:0];
    endfunction

    function automatic logic [7:0] exp_rd(logic [7:0] a);
        logic [11:0] s [7];
        s = '{cur_axis.x, cur_axis.y, cur_axis.z, vector_magnitude_output_data,
              buf_axis.x, buf_axis.y, buf_axis.z};
        if (a == 8'h01) return temp_data;
        if (a >= 8'h04 && a <= 8'h11) return fmt(s[(a - 8'h04) >> 1], a[0]);
        case (a)
            8'h16:   return m_setup;
            8'h17:   return m_rate;
            8'h1A:   return m_idle[7:0];
            8'h1B:   return {4'h0, m_idle[11:8]};
            8'h1C:   return {7'h00, boot_mode_pin && m_setup[5:4] != 2'b00};
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] exp_ptr(logic [7:0] a);
        logic f;
        f = m_setup[0];
        if (a == 8'h01) return 8'h04;
        if (a == 8'h0B || (f && a == 8'h0A)) return m_setup[1] ? 8'h01 : 8'h04;
        if (a == 8'h11 || (f && a == 8'h10)) return 8'h0C;
        if (a >= 8'h04 && a <= 8'h11 && f && !a[0]) return a + 8'h02;
        return a + 8'h01;
    endfunction

    function automatic spf_pkg::spf_sleep_cfg_t exp_cfg();
        spf_pkg::spf_sleep_cfg_t e;
        e = '0;
        if (m_setup[5]) begin
            e.mode     = spf_pkg::SPF_FPM;
            e.dec_code = m_rate[3:0];
            e.idle     = m_idle;
        end else if (m_setup[4]) begin
            e.mode      = spf_pkg::SPF_HPM;
            e.rate_code = m_rate[3:0];
        end else begin
            e.rate_code = m_rate[3:0];
        end
        return e;
    endfunction

    // ****************************************************************
    // Compares and bus helpers
    // ****************************************************************
    task automatic chk_byte(logic [7:0] g, logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_cfg(spf_pkg::spf_sleep_cfg_t g,
                           spf_pkg::spf_sleep_cfg_t e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [7:0] v;
        v = d;
        // Host keeps low-power sleep under motion boot
        if (boot_mode_pin && !u_host.allow_breach && a == 8'h16) begin
            v[5:4] = 2'b00;
        end
        case (a)
            8'h16:   m_setup = v;
            8'h17:   m_rate = d;
            8'h1A:   m_idle[7:0] = d;
            8'h1B:   m_idle[11:8] = d[3:0];
            default: ;
        endcase
        u_host.wr(a, d);
    endtask

    // Read data and the pointer that follows it
    task automatic rd_chk(logic [7:0] a);
        logic [7:0] e;
        logic [7:0] p;
        e = exp_rd(a);
        p = exp_ptr(a);
        u_host.rd(a, got);
        chk_byte(got, e);
        chk_byte(auto_inc_addr, p);
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // About 640 cycles expected, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        resetn        = 1'b0;
        cur_axis      = '0;
        buf_axis      = '0;
        vector_magnitude_output_data     = 12'h000;
        temp_data     = 8'h00;
        boot_mode_pin = 1'b0;
        fails         = 0;
        cmp_count     = 0;
        m_setup       = 8'h00;
        m_rate        = 8'h00;
        m_idle        = 12'h000;
        void'($urandom(42));
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        #1 chk_cfg(sleep_cfg, exp_cfg());
        rd_chk(8'h30);
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C);
        wr(8'h16, 8'hFF);
        rd_chk(8'h16);
        for (int sel = 0; sel < 4; sel++) begin
            wr(8'h17, {4'h0, 4'($urandom)});
            wr(8'h1A, 8'($urandom));
            wr(8'h1B, {4'h0, 4'($urandom)});
            wr(8'h16, {2'b00, 2'(sel), 4'h0});
            repeat (2) @(posedge ref_clk);
            #1 chk_cfg(sleep_cfg, exp_cfg());
        end
        for (int c = 0; c < 8; c++) begin
            @(posedge ref_clk);
            cur_axis  <= spf_pkg::spf_axis_t'(36'({$urandom, $urandom}));
            buf_axis  <= spf_pkg::spf_axis_t'(36'({$urandom, $urandom}));
            vector_magnitude_output_data <= 12'($urandom);
            temp_data <= 8'($urandom);
            wr(8'h16, {4'h0, c[2], 1'b0, c[1], c[0]});
            for (int a = 0; a < 32; a++) begin
                rd_chk(8'(a));
            end
        end
        // Warning flag follows the synchronised boot pin
        @(posedge ref_clk);
        boot_mode_pin <= 1'b1;
        // Let the pin settle before the host looks at it
        @(posedge ref_clk);
        wr(8'h16, 8'h10);
        repeat (5) @(posedge ref_clk);
        #1 chk_byte({7'h00, config_warn}, 8'h00);
        rd_chk(8'h16);
        u_host.allow_breach = 1'b1;
        wr(8'h16, 8'h20);
        repeat (4) @(posedge ref_clk);
        #1 chk_byte({7'h00, config_warn}, 8'h01);
        rd_chk(8'h1C);
        wr(8'h16, 8'h00);
        repeat (4) @(posedge ref_clk);
        #1 chk_byte({7'h00, config_warn}, 8'h00);
        // Second reset in mid-run clears the settings
        wr(8'h16, 8'h38);
        @(posedge ref_clk);
        resetn  <= 1'b0;
        m_setup = 8'h00;
        m_rate  = 8'h00;
        m_idle  = 12'h000;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        #1 chk_cfg(sleep_cfg, exp_cfg());
        rd_chk(8'h16);
        rd_chk(8'h1B);
        tally_and_finish();
    end
endmodule
